//--- core/dmacp_engine.sv
module dmacp_engine
   import dmacp_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int NPER   = 16
)(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   output logic                   m_req_o,
   output logic                   m_we_o,
   output logic      [31:0]       m_addr_o,
   output logic      [1:0]        m_size_o,
   output logic      [31:0]       m_wdata_o,
   output logic                   m_lock_o,
   input  wire logic              m_ack_i,
   input  wire logic [31:0]       m_rdata_i,
   input  wire logic [NPER-1:0]   periph_first_req_i,
   input  wire logic [NPER-1:0]   periph_second_req_i,
   output logic      [NPER-1:0]   periph_first_ack_o,
   output logic      [NPER-1:0]   periph_second_ack_o,
   output logic      [NUM_CH-1:0] irq_o
);
   logic [15:0]       src_lo_reg [NUM_CH];
   logic [15:0]       src_hi_reg [NUM_CH];
   logic [15:0]       dst_lo_reg [NUM_CH];
   logic [15:0]       dst_hi_reg [NUM_CH];
   logic [15:0]       icnt_reg   [NUM_CH];
   logic [15:0]       len_reg    [NUM_CH];
   logic [15:0]       ctrl_reg   [NUM_CH];
   logic [15:0]       idx_reg    [NUM_CH];
   logic [3:0]        sel_reg;
   logic [31:0]       prdata_reg;
   logic              pready_reg;
   logic              pslverr_reg;
   dmacp_state_t      state_reg;
   logic              cur_reg;
   logic              lock_reg;
   logic [31:0]       data_reg;
   logic              req_reg;
   logic              we_reg;
   logic [31:0]       addr_reg;
   logic [1:0]        size_reg;
   logic [NUM_CH-1:0] irq_reg;
   logic [NUM_CH-1:0] pend_reg;
   logic [NUM_CH-1:0] dreq_d_reg;
   logic [NPER-1:0]   fack_reg;
   logic [NPER-1:0]   sack_reg;
   logic [NPER-1:0]   first_s;
   logic [NPER-1:0]   second_s;
   logic [NUM_CH-1:0] dreq_now;
   logic [NUM_CH-1:0] ready;
   logic              win;
   logic              any_ready;
   logic [5:0]        rel;
   logic              hit_ch;
   logic              hit_route;
   logic              ch_sel;
   logic [2:0]        fld;
   logic              apb_wr;
   logic              item_done;
   logic              last_item;
   logic              wrap;
   logic [31:0]       rd_next;

   function automatic logic [1:0] width_code(input logic [15:0] ctl);
      logic [1:0] w;
      w = ctl[CTL_WIDTH_LSB +: 2];
      return (w == WID_HALF || w == WID_WORD) ? w : WID_BYTE;
   endfunction

   function automatic logic [31:0] item_addr(input logic [15:0] hi, input logic [15:0] lo,
                                             input logic inc, input logic [15:0] idx,
                                             input logic [15:0] ctl);
      logic [31:0] step;
      step = inc ? ({16'h0000, idx} << width_code(ctl)) : 32'h0000_0000;
      return {hi, lo} + step;
   endfunction

   dmacp_sync #(
      .W (2*NPER)
   ) u_req_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .async_i   ({periph_second_req_i, periph_first_req_i}),
      .sync_o    ({second_s, first_s})
   );

   // Register decode: byte address is four times the offset above the block base
   assign rel       = paddr_i[ADDR_W-1:2];
   assign hit_ch    = (rel < ROUTE_IDX) && !rel[0] && (paddr_i[1:0] == 2'b00);
   assign hit_route = (rel == ROUTE_IDX) && (paddr_i[1:0] == 2'b00);
   assign ch_sel    = rel[4];
   assign fld       = rel[3:1];
   assign apb_wr    = psel_i && penable_i && pready_reg && pwrite_i;

   always_comb
   begin
      rd_next = 32'h0000_0000;
      if (hit_route)
         rd_next = {16'h0000, sel_reg, 12'h000};
      else if (hit_ch)
      begin
         unique case (fld)
            FLD_SRC_LO:  rd_next = {16'h0000, src_lo_reg[ch_sel]};
            FLD_SRC_HI:  rd_next = {16'h0000, src_hi_reg[ch_sel]};
            FLD_DST_LO:  rd_next = {16'h0000, dst_lo_reg[ch_sel]};
            FLD_DST_HI:  rd_next = {16'h0000, dst_hi_reg[ch_sel]};
            FLD_IRQ_CNT: rd_next = {16'h0000, icnt_reg[ch_sel]};
            FLD_LEN:     rd_next = {16'h0000, len_reg[ch_sel]};
            FLD_CTRL:    rd_next = {16'h0000, ctrl_reg[ch_sel] & CTL_MASK};
            FLD_IDX:     rd_next = {16'h0000, idx_reg[ch_sel]};
         endcase
      end
   end

   // Answer is prepared in the setup cycle so the access phase never waits
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else if (psel_i && !penable_i)
      begin
         prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_next;
         pready_reg  <= 1'b1;
         pslverr_reg <= !(hit_ch || hit_route);
      end
      else
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // Plain software registers
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            src_lo_reg[c] <= REG_RESET;
            src_hi_reg[c] <= REG_RESET;
            dst_lo_reg[c] <= REG_RESET;
            dst_hi_reg[c] <= REG_RESET;
            icnt_reg[c]   <= REG_RESET;
            len_reg[c]    <= REG_RESET;
         end
         sel_reg <= 4'h0;
      end
      else if (apb_wr)
      begin
         if (hit_route)
            sel_reg <= pwdata_i[ROUTE_SEL_LSB +: 4];
         else if (hit_ch)
         begin
            unique case (fld)
               FLD_SRC_LO:  src_lo_reg[ch_sel] <= pwdata_i[15:0];
               FLD_SRC_HI:  src_hi_reg[ch_sel] <= pwdata_i[15:0];
               FLD_DST_LO:  dst_lo_reg[ch_sel] <= pwdata_i[15:0];
               FLD_DST_HI:  dst_hi_reg[ch_sel] <= pwdata_i[15:0];
               FLD_IRQ_CNT: icnt_reg[ch_sel]   <= pwdata_i[15:0];
               FLD_LEN:     len_reg[ch_sel]    <= pwdata_i[15:0];
               FLD_CTRL,
               FLD_IDX:     ;
            endcase
         end
      end
   end

   assign item_done = (state_reg == ST_UPDATE);
   assign last_item = (idx_reg[cur_reg] == len_reg[cur_reg]);
   assign wrap      = ctrl_reg[cur_reg][CTL_CIRC] && ctrl_reg[cur_reg][CTL_DREQ];

   // Control and index: hardware updates first, a software control write in the same cycle wins; index ignores software writes
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            ctrl_reg[c] <= REG_RESET;
            idx_reg[c]  <= REG_RESET;
         end
      end
      else
      begin
         if (item_done)
         begin
            if (last_item)
            begin
               idx_reg[cur_reg] <= REG_RESET;
               if (!wrap)
                  ctrl_reg[cur_reg][CTL_ON] <= 1'b0;
            end
            else
               idx_reg[cur_reg] <= idx_reg[cur_reg] + 16'h0001;
         end
         if (apb_wr && hit_ch && fld == FLD_CTRL)
            ctrl_reg[ch_sel] <= pwdata_i[15:0] & CTL_MASK;
      end
   end

   // Interrupt pulse, compared before the index moves
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         irq_reg <= '0;
      else
         for (int c = 0; c < NUM_CH; c++)
            irq_reg[c] <= item_done && (cur_reg == c[0]) && ctrl_reg[c][CTL_IRQ_EN]
                          && (icnt_reg[c] == idx_reg[c]);
   end

   // Peripheral pair routing; edge capture so a slow-falling request is counted once
   assign dreq_now = {second_s[sel_reg], first_s[sel_reg]};

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pend_reg   <= '0;
         dreq_d_reg <= '0;
      end
      else
      begin
         dreq_d_reg <= dreq_now;
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (dreq_now[c] && !dreq_d_reg[c])
               pend_reg[c] <= 1'b1;
            else if (item_done && cur_reg == c[0])
               pend_reg[c] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         fack_reg <= '0;
         sack_reg <= '0;
      end
      else
      begin
         fack_reg <= '0;
         sack_reg <= '0;
         if (item_done && ctrl_reg[cur_reg][CTL_DREQ])
         begin
            if (cur_reg)
               sack_reg[sel_reg] <= 1'b1;
            else
               fack_reg[sel_reg] <= 1'b1;
         end
      end
   end

   // Arbitration
   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
         ready[c] = ctrl_reg[c][CTL_ON] && (!ctrl_reg[c][CTL_DREQ] || pend_reg[c]);
   end

   always_comb
   begin
      win       = 1'b0;
      any_ready = 1'b0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         // Strict compare in ascending order keeps the lower channel on ties
         if (ready[c] && (!any_ready
             || ctrl_reg[c][CTL_PRIO_LSB +: 3] > ctrl_reg[win][CTL_PRIO_LSB +: 3]))
         begin
            win       = c[0];
            any_ready = 1'b1;
         end
      end
      if (lock_reg && ready[cur_reg])
         win = cur_reg;
   end

   // Item engine
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_IDLE;
         cur_reg   <= 1'b0;
         lock_reg  <= 1'b0;
         data_reg  <= 32'h0000_0000;
         req_reg   <= 1'b0;
         we_reg    <= 1'b0;
         addr_reg  <= 32'h0000_0000;
         size_reg  <= WID_BYTE;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               if (!ready[cur_reg])
                  lock_reg <= 1'b0;
               if (any_ready)
               begin
                  cur_reg  <= win;
                  req_reg  <= 1'b1;
                  size_reg <= width_code(ctrl_reg[win]);
                  lock_reg <= !ctrl_reg[win][CTL_DREQ]
                              && (!ctrl_reg[win][CTL_IDLE] || ctrl_reg[win][CTL_INIT]);
                  if (ctrl_reg[win][CTL_INIT] && idx_reg[win] != 16'h0000)
                  begin
                     // Fill value already held from the single source fetch
                     we_reg    <= 1'b1;
                     addr_reg  <= item_addr(dst_hi_reg[win], dst_lo_reg[win], ctrl_reg[win][CTL_DINC],
                                            idx_reg[win], ctrl_reg[win]);
                     state_reg <= ST_WRITE;
                  end
                  else
                  begin
                     we_reg    <= 1'b0;
                     addr_reg  <= item_addr(src_hi_reg[win], src_lo_reg[win], ctrl_reg[win][CTL_SINC],
                                            idx_reg[win], ctrl_reg[win]);
                     state_reg <= ST_READ;
                  end
               end
            end
            ST_READ:
            begin
               if (m_ack_i)
               begin
                  data_reg  <= m_rdata_i;
                  we_reg    <= 1'b1;
                  addr_reg  <= item_addr(dst_hi_reg[cur_reg], dst_lo_reg[cur_reg], ctrl_reg[cur_reg][CTL_DINC],
                                         idx_reg[cur_reg], ctrl_reg[cur_reg]);
                  state_reg <= ST_WRITE;
               end
            end
            ST_WRITE:
            begin
               if (m_ack_i)
               begin
                  req_reg   <= 1'b0;
                  we_reg    <= 1'b0;
                  state_reg <= ST_UPDATE;
               end
            end
            ST_UPDATE:
            begin
               if (last_item && !wrap)
                  lock_reg <= 1'b0;
               // Idle bit only matters without peripheral requests
               if (ctrl_reg[cur_reg][CTL_IDLE] && !ctrl_reg[cur_reg][CTL_DREQ])
                  state_reg <= ST_GAP;
               else
                  state_reg <= ST_IDLE;
            end
            ST_GAP:
               state_reg <= ST_IDLE;
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   assign prdata_o            = prdata_reg;
   assign pready_o            = pready_reg;
   assign pslverr_o           = pslverr_reg;
   assign m_req_o             = req_reg;
   assign m_we_o              = we_reg;
   assign m_addr_o            = addr_reg;
   assign m_size_o            = size_reg;
   assign m_wdata_o           = data_reg;
   assign m_lock_o            = lock_reg;
   assign periph_first_ack_o  = fack_reg;
   assign periph_second_ack_o = sack_reg;
   assign irq_o               = irq_reg;
endmodule

//--- core/dmacp_pkg.sv
package dmacp_pkg;
   localparam int          NUM_CH          = 2;
   localparam logic [31:0] BLOCK_BASE      = 32'h50003560;
   localparam logic [31:0] CH6_SRC_LO_OFF  = 32'h50003560;
   localparam logic [31:0] CH6_SRC_HI_OFF  = 32'h50003562;
   localparam logic [31:0] CH6_DST_LO_OFF  = 32'h50003564;
   localparam logic [31:0] CH6_DST_HI_OFF  = 32'h50003566;
   localparam logic [31:0] CH6_IRQ_CNT_OFF = 32'h50003568;
   localparam logic [31:0] CH6_LEN_OFF     = 32'h5000356a;
   localparam logic [31:0] CH6_CTRL_OFF    = 32'h5000356c;
   localparam logic [31:0] CH6_IDX_OFF     = 32'h5000356e;
   localparam logic [31:0] CH7_SRC_LO_OFF  = 32'h50003570;
   localparam logic [31:0] CH7_SRC_HI_OFF  = 32'h50003572;
   localparam logic [31:0] CH7_DST_LO_OFF  = 32'h50003574;
   localparam logic [31:0] CH7_DST_HI_OFF  = 32'h50003576;
   localparam logic [31:0] CH7_IRQ_CNT_OFF = 32'h50003578;
   localparam logic [31:0] CH7_LEN_OFF     = 32'h5000357a;
   localparam logic [31:0] CH7_CTRL_OFF    = 32'h5000357c;
   localparam logic [31:0] CH7_IDX_OFF     = 32'h5000357e;
   localparam logic [31:0] REQ_ROUTE_OFF   = 32'h50003580;
   // Field codes: halfword slot within one channel's block
   localparam logic [2:0]  FLD_SRC_LO      = 3'((CH6_SRC_LO_OFF - BLOCK_BASE) >> 1);
   localparam logic [2:0]  FLD_SRC_HI      = 3'((CH6_SRC_HI_OFF - BLOCK_BASE) >> 1);
   localparam logic [2:0]  FLD_DST_LO      = 3'((CH6_DST_LO_OFF - BLOCK_BASE) >> 1);
   localparam logic [2:0]  FLD_DST_HI      = 3'((CH6_DST_HI_OFF - BLOCK_BASE) >> 1);
   localparam logic [2:0]  FLD_IRQ_CNT     = 3'((CH6_IRQ_CNT_OFF - BLOCK_BASE) >> 1);
   localparam logic [2:0]  FLD_LEN         = 3'((CH6_LEN_OFF - BLOCK_BASE) >> 1);
   localparam logic [2:0]  FLD_CTRL        = 3'((CH6_CTRL_OFF - BLOCK_BASE) >> 1);
   localparam logic [2:0]  FLD_IDX         = 3'((CH6_IDX_OFF - BLOCK_BASE) >> 1);
   localparam logic [5:0]  ROUTE_IDX       = 6'(REQ_ROUTE_OFF - BLOCK_BASE);
   localparam int          CTL_ON          = 0;
   localparam int          CTL_WIDTH_LSB   = 1;
   localparam int          CTL_IRQ_EN      = 3;
   localparam int          CTL_DREQ        = 4;
   localparam int          CTL_DINC        = 5;
   localparam int          CTL_SINC        = 6;
   localparam int          CTL_CIRC        = 7;
   localparam int          CTL_PRIO_LSB    = 8;
   localparam int          CTL_IDLE        = 11;
   localparam int          CTL_INIT        = 12;
   localparam logic [15:0] CTL_MASK        = 16'h1fff;
   localparam int          ROUTE_SEL_LSB   = 12;
   localparam logic [15:0] REG_RESET       = 16'h0000;
   localparam logic [1:0]  WID_BYTE        = 2'b00;
   localparam logic [1:0]  WID_HALF        = 2'b01;
   localparam logic [1:0]  WID_WORD        = 2'b10;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_READ   = 3'b001,
      ST_WRITE  = 3'b010,
      ST_UPDATE = 3'b011,
      ST_GAP    = 3'b100
   } dmacp_state_t;
endpackage

//--- core/dmacp_sync.sv
module dmacp_sync
   import dmacp_pkg::*;
#(
   parameter int W = 16
)(
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // First stage feeds only the second one
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule

//--- test/dmacp_mem_model.sv
module dmacp_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [1:0]  size_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [1:0]  wait_i,
   output logic             ack_o,
   output logic      [31:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [logic [31:0]];
   logic [31:0] wa_q [$];
   logic [31:0] wd_q [$];
   logic [1:0]  ws_q [$];
   int          reads;
   logic [1:0]  cnt;
   // Registered ack gives at least one wait state
   always @(posedge clk_sys_i)
   begin
      ack_o <= 1'h0;
      // Stale read data flips so it never passes for valid
      rdata_o <= ~rdata_o;
      if (rst_i)
      begin
         cnt <= 2'h0;
         rdata_o <= 32'h0;
      end
      else if (req_i && !ack_o)
      begin
         if (cnt != wait_i)
            cnt <= cnt + 2'h1;
         else
         begin
            cnt <= 2'h0;
            ack_o <= 1'h1;
            if (we_i)
            begin
               mem[addr_i] = wdata_i;
               wa_q.push_back(addr_i);
               wd_q.push_back(wdata_i);
               ws_q.push_back(size_i);
            end
            else
            begin
               rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~addr_i;
               reads++;
            end
         end
      end
   end
endmodule

//--- test/dmacp_props.sv
module dmacp_props
   import dmacp_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int NPER   = 16
)(
   input wire logic              clk_sys_i,
   input wire logic              rst_i,
   input wire logic              m_req_o,
   input wire logic              m_we_o,
   input wire logic [31:0]       m_addr_o,
   input wire logic [1:0]        m_size_o,
   input wire logic [31:0]       m_wdata_o,
   input wire logic              m_ack_i,
   input wire logic [31:0]       m_rdata_i,
   input wire logic [NPER-1:0]   periph_first_ack_o,
   input wire logic [NPER-1:0]   periph_second_ack_o,
   input wire logic [NUM_CH-1:0] irq_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   sequence rd_done;
      m_req_o && !m_we_o && m_ack_i;
   endsequence
   sequence wr_done;
      m_req_o && m_we_o && m_ack_i;
   endsequence
   chk_width_legal: assert property (m_req_o |-> m_size_o != 2'h3)
      else $error("reserved width on bus");
   chk_req_held: assert property (
      m_req_o && !m_ack_i |=> m_req_o && $stable(m_addr_o) && $stable(m_we_o) && $stable(m_size_o))
      else $error("bus request changed before ack");
   chk_read_write: assert property (rd_done |=> m_req_o && m_we_o && $stable(m_size_o))
      else $error("read not followed by write");
   chk_data_pass: assert property (rd_done |=> m_wdata_o == $past(m_rdata_i))
      else $error("write data differs from read data");
   chk_item_gap: assert property (wr_done |=> !m_req_o [*2])
      else $error("next item started too soon");
   chk_irq_pulse: assert property (|irq_o |=> irq_o == '0)
      else $error("interrupt longer than one cycle");
   chk_irq_cause: assert property (|irq_o |-> $past(m_req_o && m_we_o && m_ack_i, 2))
      else $error("interrupt without finished item");
   chk_ack_cause: assert property (
      (|periph_first_ack_o || |periph_second_ack_o) |-> $past(m_req_o && m_we_o && m_ack_i, 2))
      else $error("request ack without finished item");
endmodule

bind dmacp_engine dmacp_props #(.ADDR_W(ADDR_W), .NPER(NPER)) u_props (
   .clk_sys_i, .rst_i, .m_req_o, .m_we_o, .m_addr_o, .m_size_o, .m_wdata_o,
   .m_ack_i, .m_rdata_i, .periph_first_ack_o, .periph_second_ack_o, .irq_o
);

//--- test/tb.sv
module tb;
   import dmacp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, m_req, m_we, m_lock, m_ack, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, m_addr, m_wdata, m_rdata;
   logic [1:0]  m_size, wait_c, irq;
   logic [15:0] freq, sreq, fack, sack;
   int          num_errors, check_count, irq_n, ack_n, lock_n;
   dmacp_engine uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .m_req_o(m_req), .m_we_o(m_we), .m_addr_o(m_addr), .m_size_o(m_size),
      .m_wdata_o(m_wdata), .m_lock_o(m_lock), .m_ack_i(m_ack), .m_rdata_i(m_rdata),
      .periph_first_req_i(freq), .periph_second_req_i(sreq), .periph_first_ack_o(fack),
      .periph_second_ack_o(sack), .irq_o(irq));
   dmacp_mem_model mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(m_req), .we_i(m_we),
      .addr_i(m_addr), .size_i(m_size), .wdata_i(m_wdata), .wait_i(wait_c), .ack_o(m_ack),
      .rdata_o(m_rdata));
   initial
   begin
      clk_sys_i = 1'h0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i)
   begin
      // Only channel 7 raises interrupts here, so a pulse on the wrong bit is caught
      if (irq === 2'h2)
         irq_n++;
      if (m_req === 1'h1 && m_lock === 1'h1)
         lock_n++;
      if ((|fack) === 1'h1 || (|sack) === 1'h1)
         ack_n++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One idle cycle after each transfer keeps psel from being driven twice per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] r);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge clk_sys_i);
      penable <= 1'h1;
      do @(posedge clk_sys_i); while (pready !== 1'h1);
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      apb(1'h1, a, d, r);
   endtask
   function automatic logic [7:0] ra(input logic c, input logic [2:0] f);
      return {1'h0, c, f, 3'h0};
   endfunction
   task automatic wait_off(input logic c);
      logic [31:0] r;
      do apb(1'h0, ra(c, FLD_CTRL), 16'h0, r); while (r[0] !== 1'h0);
   endtask
   task automatic setup(input logic c, input logic [31:0] s, input logic [31:0] d, input logic [15:0] n);
      wr(ra(c, FLD_SRC_LO), s[15:0]);
      wr(ra(c, FLD_SRC_HI), s[31:16]);
      wr(ra(c, FLD_DST_LO), d[15:0]);
      wr(ra(c, FLD_DST_HI), d[31:16]);
      wr(ra(c, FLD_LEN), n);
      wr(ra(c, FLD_IRQ_CNT), 16'h1);
      mem.wa_q.delete();
      mem.wd_q.delete();
      mem.ws_q.delete();
      mem.reads = 0;
      irq_n = 0;
      ack_n = 0;
      lock_n = 0;
   endtask
   task automatic t_regs();
      logic [31:0] r;
      apb(1'h0, ra(1'h1, FLD_SRC_LO), 16'h0, r);
      chk(r, 32'h0);
      wr(ra(1'h1, FLD_DST_HI), 16'hbeef);
      apb(1'h0, ra(1'h1, FLD_DST_HI), 16'h0, r);
      chk(r, 32'hbeef);
      wr(ra(1'h1, FLD_CTRL), 16'hfffe);
      apb(1'h0, ra(1'h1, FLD_CTRL), 16'h0, r);
      chk(r, 32'h1ffe);
      wr(ra(1'h1, FLD_CTRL), 16'h0);
      wr(ra(1'h0, FLD_IDX), 16'h5555);
      apb(1'h0, ra(1'h0, FLD_IDX), 16'h0, r);
      chk(r, 32'h0);
      apb(1'h0, 8'h84, 16'h0, r);
      chk({31'h0, err}, 32'h1);
   endtask
   task automatic t_copy(input logic [1:0] w, input logic si, input logic di, input logic ie);
      int st;
      st = (w == WID_HALF) ? 2 : (w == WID_WORD) ? 4 : 1;
      for (int i = 0; i < 3; i++)
         mem.mem[32'h11000 + i * st] = 32'ha5a50000 + i;
      wait_c <= {1'h0, w[0]};
      setup(1'h1, 32'h11000, 32'h22000, 16'h2);
      wr(ra(1'h1, FLD_CTRL), {4'h0, w[0], 4'h0, si, di, 1'h0, ie, w, 1'h1});
      wait_off(1'h1);
      chk(mem.wa_q.size(), 32'h3);
      for (int i = 0; i < 3; i++)
      begin
         chk(mem.wa_q[i], 32'h22000 + (di ? i * st : 0));
         chk(mem.wd_q[i], 32'ha5a50000 + (si ? i : 0));
         chk({30'h0, mem.ws_q[i]}, {30'h0, (w == 2'h3) ? WID_BYTE : w});
      end
      chk(irq_n, {31'h0, ie});
      chk({31'h0, lock_n != 0}, {31'h0, !w[0]});
   endtask
   task automatic t_init();
      mem.mem[32'h11000] = 32'hc0dec0de;
      setup(1'h1, 32'h11000, 32'h33000, 16'h3);
      wr(ra(1'h1, FLD_CTRL), 16'h1065);
      wait_off(1'h1);
      chk(mem.reads, 32'h1);
      chk({31'h0, lock_n != 0}, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         chk(mem.wd_q[i], 32'hc0dec0de);
         chk(mem.wa_q[i], 32'h33000 + 4 * i);
      end
   endtask
   task automatic t_dreq();
      logic [31:0] r;
      wr(8'h80, 16'h3000);
      setup(1'h0, 32'h11000, 32'h44000, 16'h0);
      wr(ra(1'h0, FLD_CTRL), 16'h00b5);
      repeat (20) @(posedge clk_sys_i);
      chk(mem.reads, 32'h0);
      freq[3] <= 1'h1;
      while (ack_n == 0) @(posedge clk_sys_i);
      freq[3] <= 1'h0;
      chk(mem.wa_q[0], 32'h44000);
      chk(lock_n, 32'h0);
      apb(1'h0, ra(1'h0, FLD_CTRL), 16'h0, r);
      chk(r, 32'hb5);
      apb(1'h0, ra(1'h0, FLD_IDX), 16'h0, r);
      chk(r, 32'h0);
      wr(ra(1'h0, FLD_CTRL), 16'h0);
   endtask
   task automatic t_prio(input logic [2:0] p6, input logic [2:0] p7, input logic [31:0] exp);
      wr(8'h80, 16'h5000);
      setup(1'h0, 32'h3000, 32'h55000, 16'h0);
      setup(1'h1, 32'h4000, 32'h66000, 16'h0);
      wr(ra(1'h0, FLD_CTRL), {5'h0, p6, 8'h15});
      wr(ra(1'h1, FLD_CTRL), {5'h0, p7, 8'h15});
      wait_c <= 2'h2;
      freq[5] <= 1'h1;
      sreq[5] <= 1'h1;
      while (m_req !== 1'h1) @(negedge clk_sys_i);
      chk(m_addr, exp);
      @(posedge clk_sys_i);
      freq[5] <= 1'h0;
      sreq[5] <= 1'h0;
      wait_off(1'h0);
      wait_off(1'h1);
      chk(ack_n, 32'h2);
   endtask
   initial
   begin
      rst_i = 1'h1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {freq, sreq, wait_c} = '0;
      {num_errors, check_count, irq_n, ack_n, lock_n} = '0;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      @(posedge clk_sys_i);
      t_regs();
      t_copy(WID_BYTE, 1'h1, 1'h1, 1'h1);
      t_copy(WID_HALF, 1'h1, 1'h0, 1'h1);
      t_copy(WID_WORD, 1'h0, 1'h1, 1'h1);
      t_copy(2'h3, 1'h1, 1'h1, 1'h0);
      t_init();
      t_dreq();
      t_prio(3'h1, 3'h5, 32'h4000);
      t_prio(3'h3, 3'h3, 32'h3000);
      t_prio(3'h6, 3'h2, 32'h3000);
      summarize();
   end
   // Whole run needs under a thousand cycles; the 40000-cycle limit is ample
   initial
   begin
      #200000;
      num_errors++;
      summarize();
   end
endmodule
